// ==== bcd_defs.svh ====
// Contract
// - Signed less-or-equal and not-greater jumps are taken when zero is set or sign differs from overflow.
// - Signed greater and not-less-or-equal jumps are taken only when zero is clear and sign equals overflow.
// - Above and below conditions use carry and zero as unsigned; greater and less use sign, overflow and zero as signed.
// - With sign-extend bit 0 and word bit 1, two immediate bytes form a full 16-bit operand.
// - With sign-extend bit 1 and word bit 1, one immediate byte is sign-extended to 16 bits.
// - The low bit of the repeat prefix selects the zero value that repeated compare and scan operations test.
// - Accumulator forms use the byte accumulator for byte operations and the word accumulator for word operations.
// - Variable-port input and output take the port address from the port register, not an immediate byte.
// - Jump-if-not-below decodes from its opcode followed by a signed 8-bit displacement byte.
// - Loop-while-nonzero decrements the count and branches only while the count is nonzero and zero is clear.
`ifndef BCD_DEFS_SVH
`define BCD_DEFS_SVH

`define BCD_ADR_W 8
`define BCD_REG_CTRL 8'h00
`define BCD_REG_STATUS 8'h04
`define BCD_REG_OPCODE 8'h08
`define BCD_REG_IMM 8'h0c
`define BCD_REG_DISP 8'h10
`define BCD_REG_PORT 8'h14

`define BCD_CTRL_EN 0
`define BCD_CTRL_RST 1'b1

`define BCD_ST_TAKEN 0
`define BCD_ST_ACC_USED 1
`define BCD_ST_ACC_WORD 2
`define BCD_ST_PORT_DX 3
`define BCD_ST_REP_ACTIVE 4
`define BCD_ST_REP_Z 5
`define BCD_ST_REP_CONT 6
`define BCD_ST_BUSY 7

`define BCD_OP_JCC_HI 4'h7
`define BCD_OP_LOOP_HI 6'h38
`define BCD_OP_REP_HI 7'h79
`define BCD_OP_GRP_HI 6'h20
`define BCD_OP_TEST_ACC_HI 7'h54
`define BCD_OP_CMPS_HI 7'h53
`define BCD_OP_SCAS_HI 7'h57
`define BCD_OP_IN_IMM_HI 6'h39
`define BCD_OP_IN_DX_HI 6'h3b

`endif

// ==== bcd_pkg.sv ====
package bcd_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_MODRM,
    ST_EA_DISP,
    ST_IMM_LO,
    ST_IMM_HI,
    ST_BRANCH_DISP
  } bcd_state_t;

  // Order follows the low two opcode bits of the loop group
  typedef enum logic [1:0] {
    LK_NONZERO,
    LK_ZERO,
    LK_ALWAYS,
    LK_CX_ZERO
  } bcd_loop_kind_t;
endpackage

// ==== bcd_cond_eval.sv ====
`timescale 1ns/1ps
module bcd_cond_eval (
  input wire logic [3:0] cond_code,
  input wire bcd_pkg::bcd_loop_kind_t loop_kind,
  input wire logic zero_flag,
  input wire logic sign_flag,
  input wire logic overflow_flag,
  input wire logic carry_flag,
  input wire logic parity_flag,
  input wire logic [15:0] count_now,
  output logic jcc_taken,
  output logic loop_taken
);
  import bcd_pkg::*;

  logic base;
  logic [15:0] count_dec;
  logic sign_ne_ovf;
  logic count_left;

  assign sign_ne_ovf = sign_flag ^ overflow_flag;
  assign count_dec = count_now - 16'h0001;
  assign count_left = |count_dec;

  always_comb begin
    case (cond_code[3:1])
      3'h0: base = overflow_flag;
      3'h1: base = carry_flag;
      3'h2: base = zero_flag;
      3'h3: base = carry_flag | zero_flag;
      3'h4: base = sign_flag;
      3'h5: base = parity_flag;
      3'h6: base = sign_ne_ovf;
      3'h7: base = sign_ne_ovf | zero_flag;
      default: base = 1'b0;
    endcase
  end

  // Odd codes are the negated forms
  assign jcc_taken = base ^ cond_code[0];

  always_comb begin
    case (loop_kind)
      LK_NONZERO: loop_taken = count_left & ~zero_flag;
      LK_ZERO: loop_taken = count_left & zero_flag;
      LK_ALWAYS: loop_taken = count_left;
      LK_CX_ZERO: loop_taken = ~|count_now;
      default: loop_taken = 1'b0;
    endcase
  end
endmodule

// ==== bcd_imm_decode.sv ====
`timescale 1ns/1ps
`include "bcd_defs.svh"
module bcd_imm_decode (
  input wire logic [7:0] opcode,
  input wire logic [7:0] modrm,
  output logic has_modrm,
  output logic [1:0] ea_len,
  output logic [1:0] imm_len,
  output logic imm_sext,
  output logic acc_form,
  output logic acc_word,
  output logic port_imm,
  output logic port_dx
);
  logic grp;
  logic alu_acc;
  logic io_op;
  logic sw_word;

  assign grp = opcode[7:2] == `BCD_OP_GRP_HI;
  assign alu_acc = (opcode[7:6] == 2'b00 && opcode[2:1] == 2'b10)
    || opcode[7:1] == `BCD_OP_TEST_ACC_HI;
  assign port_imm = opcode[7:2] == `BCD_OP_IN_IMM_HI;
  assign port_dx = opcode[7:2] == `BCD_OP_IN_DX_HI;
  assign io_op = port_imm | port_dx;
  assign has_modrm = grp;

  // Two bytes only for s:w = 01
  assign sw_word = ~opcode[1] & opcode[0];
  assign imm_sext = grp & opcode[1] & opcode[0];

  always_comb begin
    if (grp) begin
      imm_len = sw_word ? 2'd2 : 2'd1;
    end else if (alu_acc) begin
      imm_len = opcode[0] ? 2'd2 : 2'd1;
    end else if (port_imm) begin
      imm_len = 2'd1;
    end else begin
      imm_len = 2'd0;
    end
  end

  assign acc_form = alu_acc | io_op;
  assign acc_word = opcode[0];

  always_comb begin
    case (modrm[7:6])
      2'b00: ea_len = (modrm[2:0] == 3'b110) ? 2'd2 : 2'd0;
      2'b01: ea_len = 2'd1;
      2'b10: ea_len = 2'd2;
      default: ea_len = 2'd0;
    endcase
  end
endmodule

// ==== bcd_top.sv ====
`timescale 1ns/1ps
`include "bcd_defs.svh"
module bcd_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`BCD_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ib_valid,
  input wire logic [7:0] ib_data,
  output logic ib_ready,
  input wire logic zero_flag,
  input wire logic sign_flag,
  input wire logic overflow_flag,
  input wire logic carry_flag,
  input wire logic parity_flag,
  input wire logic [15:0] count_register,
  input wire logic [15:0] variable_port_register,
  output logic dec_done,
  output logic jump_taken,
  output logic [7:0] branch_disp,
  output logic [15:0] imm_operand,
  output logic acc_used,
  output logic acc_word,
  output logic [15:0] port_addr,
  output logic port_from_dx,
  output logic [15:0] count_next,
  output logic count_we,
  output logic rep_z,
  output logic rep_continue
);
  import bcd_pkg::*;

  logic [1:0] rst_sync;
  logic rst_n;
  bcd_state_t state;
  bcd_state_t next_state;
  logic [7:0] opcode;
  logic [7:0] modrm;
  logic [7:0] imm_lo;
  logic [1:0] ea_left;
  logic rep_active;
  logic ctrl_en;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Decoder inputs follow the byte being taken
  wire take = ib_valid & ib_ready;
  wire in_op = state == ST_OPCODE;
  wire [7:0] dec_op = in_op ? ib_data : opcode;
  wire [7:0] dec_modrm = (state == ST_MODRM) ? ib_data : modrm;

  wire has_modrm;
  wire [1:0] ea_len;
  wire [1:0] imm_len;
  wire imm_sext;
  wire acc_form;
  wire acc_w;
  wire port_imm;
  wire port_dx;

  bcd_imm_decode u_imm (
    .opcode(dec_op),
    .modrm(dec_modrm),
    .has_modrm(has_modrm),
    .ea_len(ea_len),
    .imm_len(imm_len),
    .imm_sext(imm_sext),
    .acc_form(acc_form),
    .acc_word(acc_w),
    .port_imm(port_imm),
    .port_dx(port_dx)
  );

  wire jcc_taken;
  wire loop_taken;
  wire is_loop = opcode[7:2] == `BCD_OP_LOOP_HI;

  bcd_cond_eval u_cond (
    .cond_code(opcode[3:0]),
    .loop_kind(bcd_loop_kind_t'(opcode[1:0])),
    .zero_flag(zero_flag),
    .sign_flag(sign_flag),
    .overflow_flag(overflow_flag),
    .carry_flag(carry_flag),
    .parity_flag(parity_flag),
    .count_now(count_register),
    .jcc_taken(jcc_taken),
    .loop_taken(loop_taken)
  );

  // Opcode classes seen in the opcode byte
  wire op_branch = ib_data[7:4] == `BCD_OP_JCC_HI || ib_data[7:2] == `BCD_OP_LOOP_HI;
  wire op_rep = ib_data[7:1] == `BCD_OP_REP_HI;
  wire op_str_cmp = ib_data[7:1] == `BCD_OP_CMPS_HI || ib_data[7:1] == `BCD_OP_SCAS_HI;
  wire imm_two = imm_len == 2'd2;
  wire imm_none = imm_len == 2'd0;
  wire last_imm = state == ST_IMM_HI || (state == ST_IMM_LO && !imm_two);
  wire [15:0] imm_one = imm_sext ? {{8{ib_data[7]}}, ib_data} : {8'h00, ib_data};
  wire finish_op = in_op && !op_branch && !has_modrm && imm_none;
  wire finish = take && (finish_op || last_imm || state == ST_BRANCH_DISP);
  wire loop_dec = is_loop && opcode[1:0] != 2'b11;

  assign ib_ready = ctrl_en & ce;

  always_comb begin
    next_state = state;
    if (take) begin
      case (state)
        ST_OPCODE: begin
          if (op_branch) begin
            next_state = ST_BRANCH_DISP;
          end else if (has_modrm) begin
            next_state = ST_MODRM;
          end else if (!imm_none) begin
            next_state = ST_IMM_LO;
          end
        end
        ST_MODRM: next_state = (ea_len != 2'd0) ? ST_EA_DISP : ST_IMM_LO;
        ST_EA_DISP: next_state = (ea_left == 2'd1) ? ST_IMM_LO : ST_EA_DISP;
        ST_IMM_LO: next_state = imm_two ? ST_IMM_HI : ST_OPCODE;
        ST_IMM_HI: next_state = ST_OPCODE;
        ST_BRANCH_DISP: next_state = ST_OPCODE;
        default: next_state = ST_OPCODE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_OPCODE;
      opcode <= 8'h00;
      modrm <= 8'h00;
      ea_left <= 2'd0;
    end else if (ce) begin
      state <= next_state;
      if (take && in_op) begin
        opcode <= ib_data;
      end
      if (take && state == ST_MODRM) begin
        modrm <= ib_data;
        ea_left <= ea_len;
      end else if (take && state == ST_EA_DISP) begin
        ea_left <= ea_left - 2'd1;
      end
    end
  end

  // Operand assembly
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      imm_lo <= 8'h00;
      imm_operand <= 16'h0000;
      port_addr <= 16'h0000;
      port_from_dx <= 1'b0;
      acc_used <= 1'b0;
      acc_word <= 1'b0;
    end else if (ce && take) begin
      if (in_op) begin
        acc_used <= acc_form;
        acc_word <= acc_form & acc_w;
        port_from_dx <= port_dx;
        if (port_dx) begin
          port_addr <= variable_port_register;
        end
      end
      if (state == ST_IMM_LO) begin
        imm_lo <= ib_data;
        imm_operand <= imm_one;
        if (port_imm) begin
          port_addr <= {8'h00, ib_data};
        end
      end
      if (state == ST_IMM_HI) begin
        imm_operand <= {ib_data, imm_lo};
      end
    end
  end

  // Branch outcome and count update
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      jump_taken <= 1'b0;
      branch_disp <= 8'h00;
      count_next <= 16'h0000;
      count_we <= 1'b0;
    end else if (ce) begin
      count_we <= 1'b0;
      if (take && state == ST_BRANCH_DISP) begin
        branch_disp <= ib_data;
        jump_taken <= is_loop ? loop_taken : jcc_taken;
        if (loop_dec) begin
          count_next <= count_register - 16'h0001;
          count_we <= 1'b1;
        end
      end else if (take && in_op) begin
        jump_taken <= 1'b0;
      end
    end
  end

  // Repeat prefix tracking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_active <= 1'b0;
      rep_z <= 1'b0;
      rep_continue <= 1'b0;
    end else if (ce && take && in_op) begin
      rep_active <= op_rep;
      if (op_rep) begin
        rep_z <= ib_data[0];
      end
      rep_continue <= rep_active && op_str_cmp && (zero_flag == rep_z);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_done <= 1'b0;
    end else if (ce) begin
      dec_done <= finish;
    end
  end

  // Register bus
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & wb_ack_o;
  wire sel_ctrl = wb_adr_i == `BCD_REG_CTRL;
  wire sel_status = wb_adr_i == `BCD_REG_STATUS;
  wire sel_opcode = wb_adr_i == `BCD_REG_OPCODE;
  wire sel_imm = wb_adr_i == `BCD_REG_IMM;
  wire sel_disp = wb_adr_i == `BCD_REG_DISP;
  wire sel_port = wb_adr_i == `BCD_REG_PORT;

  wire [7:0] status_bits = {
    state != ST_OPCODE,
    rep_continue,
    rep_z,
    rep_active,
    port_from_dx,
    acc_word,
    acc_used,
    jump_taken
  };

  wire [31:0] rd_mux =
    sel_ctrl ? {31'h0, ctrl_en} :
    sel_status ? {24'h0, status_bits} :
    sel_opcode ? {16'h0, modrm, opcode} :
    sel_imm ? {16'h0, imm_operand} :
    sel_disp ? {24'h0, branch_disp} :
    sel_port ? {16'h0, port_addr} :
    32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en <= `BCD_CTRL_RST;
    end else if (ce && bus_wr && sel_ctrl && wb_sel_i[0]) begin
      ctrl_en <= wb_dat_i[`BCD_CTRL_EN];
    end
  end
endmodule

// ==== bcd_checker.sv ====
`timescale 1ns/1ps
module bcd_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ib_valid,
  input wire logic [7:0] ib_data,
  input wire logic ib_ready,
  input wire logic zero_flag,
  input wire logic sign_flag,
  input wire logic overflow_flag,
  input wire logic carry_flag,
  input wire logic [15:0] count_register,
  input wire logic dec_done,
  input wire logic jump_taken,
  input wire logic [15:0] imm_operand,
  input wire logic acc_used,
  input wire logic acc_word,
  input wire logic [15:0] count_next,
  input wire logic count_we,
  input wire logic rep_z
);
  logic first_q, sec_q, zq, sq, oq, cq;
  logic [7:0] op_q, md_q, b0, b1;
  logic [15:0] cnt_q;
  wire take = ib_valid & ib_ready;
  // Byte accepted here opens a new instruction
  wire op_slot = first_q | dec_done;
  wire jcc_done = dec_done && op_q[7:4] == 4'h7;
  wire grp_done = dec_done && md_q[7:6] == 2'h3;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      first_q <= 1'h1;
      sec_q <= 1'h0;
    end else if (take) begin
      first_q <= 1'h0;
      sec_q <= op_slot;
    end else if (dec_done) begin
      // Opcode may arrive after an idle gap
      first_q <= 1'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (take) begin
      op_q <= op_slot ? ib_data : op_q;
      md_q <= sec_q ? ib_data : md_q;
      b1 <= b0;
      b0 <= ib_data;
      {zq, sq, oq, cq} <= {zero_flag, sign_flag, overflow_flag, carry_flag};
      cnt_q <= count_register;
    end
  end
  jle_taken_a: assert property (jcc_done && op_q[3:0] == 4'he
    |-> jump_taken == (zq | (sq ^ oq))) else $error("signed le outcome wrong");
  jg_taken_a: assert property (jcc_done && op_q[3:0] == 4'hf
    |-> jump_taken == (!zq && sq == oq)) else $error("signed gt outcome wrong");
  unsigned_cmp_a: assert property (jcc_done && op_q[3:1] == 3'h3
    |-> jump_taken == (op_q[0] ^ (cq | zq))) else $error("unsigned outcome wrong");
  not_below_a: assert property (jcc_done && op_q[3:0] == 4'h3
    |-> jump_taken == !cq) else $error("not below outcome wrong");
  loop_count_a: assert property (dec_done && op_q == 8'he0
    |-> count_we && count_next == cnt_q - 16'h1 && jump_taken == (cnt_q != 16'h1 && !zq))
    else $error("loop outcome wrong");
  imm_word_a: assert property (grp_done && op_q == 8'h81
    |-> imm_operand == {b0, b1}) else $error("word immediate wrong");
  imm_sext_a: assert property (grp_done && op_q == 8'h83
    |-> imm_operand == {{8{b0[7]}}, b0}) else $error("sign extension wrong");
  acc_size_a: assert property (dec_done && op_q[7:1] == 7'h02
    |-> acc_used && acc_word == op_q[0]) else $error("accumulator size wrong");
  rep_zero_a: assert property (dec_done && op_q[7:1] == 7'h79
    |-> rep_z == op_q[0]) else $error("repeat zero value wrong");
  cover property (jcc_done && op_q[3:0] == 4'he && jump_taken);
  cover property (dec_done && op_q == 8'he0 && jump_taken);
  cover property (dec_done && op_q[7:1] == 7'h79);
endmodule
bind bcd_top bcd_checker bcd_checker_i (.*);

// ==== branch_condition_decoder_tb.sv ====
`timescale 1ns/1ps
`include "bcd_defs.svh"
module branch_condition_decoder_tb;
  logic sys_clk = 1'h0, nrst = 1'h0, ce = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0, ib_valid = 1'h0, zero_flag = 1'h0, sign_flag = 1'h0;
  logic overflow_flag = 1'h0, carry_flag = 1'h0, parity_flag = 1'h0;
  logic [7:0] wb_adr_i = 8'h0, ib_data = 8'h0, branch_disp;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [15:0] count_register = 16'h0, variable_port_register = 16'h0;
  logic [15:0] imm_operand, port_addr, count_next;
  logic wb_ack_o, ib_ready, dec_done, jump_taken, acc_used, acc_word, port_from_dx;
  logic count_we, rep_z, rep_continue;
  int error_cnt = 0, cmp_count = 0, cyc_cnt = 0;
  bcd_top bcd_top_i (.*);
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt > 6000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  // Bytes go low first, one per cycle; checks completion a cycle after the last
  task automatic run(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      ib_valid <= 1'h1;
      ib_data <= b[8*i+:8];
    end
    @(posedge sys_clk);
    ib_valid <= 1'h0;
    #1 chk(dec_done, 1'h1);
  endtask
  task automatic setf(input logic [4:0] f, input logic [15:0] cnt);
    @(posedge sys_clk);
    {zero_flag, sign_flag, overflow_flag, carry_flag, parity_flag} <= f;
    count_register <= cnt;
  endtask
  function automatic logic jexp(input logic [3:0] c, input logic [4:0] f);
    logic z, s, o, cy, p, r;
    {z, s, o, cy, p} = f;
    case (c[3:1])
      3'h0: r = o;
      3'h1: r = cy;
      3'h2: r = z;
      3'h3: r = cy | z;
      3'h4: r = s;
      3'h5: r = p;
      3'h6: r = s ^ o;
      default: r = (s ^ o) | z;
    endcase
    return r ^ c[0];
  endfunction
  task automatic t_regs;
    wb(1'h0, `BCD_REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    wb(1'h0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    wb(1'h1, `BCD_REG_CTRL, 32'h0);
    #1 chk(ib_ready, 1'h0);
    wb(1'h1, `BCD_REG_CTRL, 32'h1);
    #1 chk(ib_ready, 1'h1);
    @(posedge sys_clk);
    ce <= 1'h0;
    #1 chk(ib_ready, 1'h0);
    @(posedge sys_clk);
    ce <= 1'h1;
    #1 chk(ib_ready, 1'h1);
  endtask
  // Every condition code against every flag combination
  task automatic t_jcc;
    for (int k = 0; k < 512; k++) begin
      setf(k[4:0], 16'h0);
      run({16'h0, k[7:0] ^ 8'h5a, 8'h70 | k[8:5]}, 2);
      chk(jump_taken, jexp(k[8:5], k[4:0]));
      chk(branch_disp, k[7:0] ^ 8'h5a);
    end
  endtask
  // All four loop forms; the count-zero jump never decrements
  task automatic t_loop;
    logic [15:0] cn [4] = '{16'h1, 16'h5, 16'h5, 16'h0};
    logic [15:0] e;
    logic z, t;
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 4; i++) begin
        z = i == 2;
        setf({z, 4'h0}, cn[i]);
        run({16'h0, 8'h7f, 6'h38, j[1:0]}, 2);
        e = cn[i] - 16'h1;
        t = (j == 3) ? cn[i] == 16'h0 : cn[i] != 16'h1 && (j == 2 || z == (j == 1));
        chk(count_we, j != 3);
        if (j != 3) begin
          chk(count_next, e);
        end
        chk(jump_taken, t);
      end
    end
  endtask
  task automatic t_imm_acc;
    run(32'h3412c081, 4);
    chk(imm_operand, 16'h3412);
    run(32'h80114683, 4);
    chk(imm_operand, 16'hff80);
    run(32'h80c082, 3);
    chk(imm_operand, 16'h0080);
    run(32'h0080c083, 3);
    chk(imm_operand, 16'hff80);
    run(32'h007fc083, 3);
    chk(imm_operand, 16'h007f);
    run(32'h5504, 2);
    chk({acc_used, acc_word}, 2'h2);
    run(32'h123405, 3);
    chk({acc_used, acc_word}, 2'h3);
  endtask
  task automatic t_port;
    @(posedge sys_clk);
    variable_port_register <= 16'habcd;
    run(32'hec, 1);
    chk({port_from_dx, port_addr}, 17'h1abcd);
    run(32'h42e4, 2);
    chk({port_from_dx, port_addr}, 17'h00042);
  endtask
  // Prefix and string opcode back to back
  task automatic t_rep;
    setf(5'h10, 16'h0);
    run(32'ha6f3, 2);
    chk({rep_z, rep_continue}, 2'h3);
    run(32'ha6f2, 2);
    chk({rep_z, rep_continue}, 2'h0);
    setf(5'h00, 16'h0);
    run(32'haef2, 2);
    chk({rep_z, rep_continue}, 2'h1);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    chk({dec_done, jump_taken, acc_used, count_we, rep_z, ib_ready}, 6'h01);
    nrst <= 1'h1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_jcc();
    t_loop();
    t_imm_acc();
    t_port();
    t_rep();
    close_out();
  end
endmodule
